/* smx_host.sv */
// Host side model: sends one control word on sync, clock and data
// Assumes the core clock paces every pin change
`timescale 1ns/1ps
`default_nettype none
module smx_host (
  input wire logic core_clk,
  output logic frame_sync_n,
  output logic serial_clk,
  output logic serial_data
);
  initial {frame_sync_n, serial_clk, serial_data} = 3'h6;
  task automatic send(input logic [7:0] w, input bit brief);
    @(posedge core_clk) frame_sync_n <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      @(posedge core_clk) serial_data <= w[i];
      repeat (3) @(posedge core_clk);
      serial_clk <= 1'b0;
      if (brief) frame_sync_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      serial_clk <= 1'b1;
    end
    serial_data <= ~w[0];
    frame_sync_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

/* smx_pkg.sv */
// Constants and types for the serial mux switch control front end
// Assumes a single core clock that oversamples the serial link pins
// Overview of operation
// [RULE1] Frame sync low arms shifter and edge counter
// [RULE2] One data bit per falling serial clock
// [RULE3] Eighth falling edge updates switches automatically
// [RULE4] Eight-bit word, most significant bit first
// [RULE5] Sync held low or briefly pulsed both work
// [RULE6] Word: all-off, bank A, bank B, spare, address
// [RULE7] Serial rate up to the specified maximum; with the 10 MHz core clock the code takes serial clocks below 5 MHz only
// [RULE8] Both bank selects high keeps present switches
// [RULE9] All-off bit high opens every switch unless both bank selects are high
// [RULE10] Address n closes source pair n+1
package smx_pkg;
  localparam int WORD_BITS = 8;
  localparam int CHANNELS = 16;
  localparam logic [3:0] EDGE_COUNT_LAST = 4'h8;
  localparam int POS_ALL_OFF = 7;
  localparam int POS_BANK_A = 6;
  localparam int POS_BANK_B = 5;
  localparam int POS_ADDR_MSB = 3;
  localparam logic [7:0] WORD_RESET = 8'h00;
  localparam logic [15:0] SWITCH_RESET = 16'h0000;
  localparam int SCLK_MAX_MHZ = 30;
  localparam int CORE_CLK_MHZ = 10;

  typedef enum logic [1:0] {
    SMX_IDLE = 2'b01,
    SMX_SHIFT = 2'b10
  } smx_state_t;

  typedef struct packed {
    logic [15:0] bank_a;
    logic [15:0] bank_b;
  } smx_switch_t;
endpackage

/* smx_serial_mux_switch_control.sv */
// Serial front end and switch state of a dual 16-channel analog mux
// Assumes sync, serial clock and data arrive asynchronously as pins
`timescale 1ns/1ps
`default_nettype none
module smx_serial_mux_switch_control (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic frame_sync_n,
  input wire logic serial_clk,
  input wire logic serial_data,
  output smx_pkg::smx_switch_t switch_on,
  output logic [7:0] last_word,
  output logic update_pulse,
  output logic frame_busy
);
  logic [2:0] sync_meta_reg, sync_reg;
  logic sclk_last_reg;
  logic sync_last_reg;
  smx_pkg::smx_state_t state_reg, state_next;
  logic [7:0] shift_reg, shift_next;
  logic [3:0] count_reg, count_next;
  smx_pkg::smx_switch_t sw_reg, sw_next;
  logic [7:0] word_reg, word_next;
  logic upd_reg, upd_next;

  // Sync, clock, data each through two flops; bit order: sync, clk, data
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_meta_reg <= 3'h7;
      sync_reg <= 3'h7;
      sclk_last_reg <= 1'b0;
      sync_last_reg <= 1'b1;
    end else begin
      sync_meta_reg <= {frame_sync_n, serial_clk, serial_data};
      sync_reg <= sync_meta_reg;
      sclk_last_reg <= sync_reg[1];
      sync_last_reg <= sync_reg[2];
    end
  end

  // Arm on the falling edge only, so a held sync does not rearm
  wire sync_fall = sync_last_reg && !sync_reg[2];
  wire sclk_fall = sclk_last_reg && !sync_reg[1];
  wire din = sync_reg[0];
  wire [7:0] shifted = {shift_reg[6:0], din}; // RULE4
  wire last_edge = (count_reg + 4'h1) == smx_pkg::EDGE_COUNT_LAST;

  function automatic smx_pkg::smx_switch_t decode(input logic [7:0] w,
                                                  input smx_pkg::smx_switch_t old);
    smx_pkg::smx_switch_t r;
    logic [15:0] onehot;
    r = old;
    onehot = 16'h0001 << w[smx_pkg::POS_ADDR_MSB -: 4]; // RULE10
    if (w[smx_pkg::POS_BANK_A] && w[smx_pkg::POS_BANK_B]) begin
      r = old; // RULE8
    end else if (w[smx_pkg::POS_ALL_OFF]) begin
      r = '0; // RULE9
    end else begin
      // Active-low selects; one bank alone leaves the other untouched
      if (!w[smx_pkg::POS_BANK_A]) r.bank_a = onehot; // RULE6
      if (!w[smx_pkg::POS_BANK_B]) r.bank_b = onehot; // RULE6
    end
    return r;
  endfunction

  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    count_next = count_reg;
    sw_next = sw_reg;
    word_next = word_reg;
    upd_next = 1'b0;
    case (state_reg)
      smx_pkg::SMX_IDLE: begin
        if (sync_fall) begin
          state_next = smx_pkg::SMX_SHIFT; // RULE1
          count_next = 4'h0;
          shift_next = smx_pkg::WORD_RESET;
        end
      end
      smx_pkg::SMX_SHIFT: begin
        // Stays armed after sync rises so a short pulse works RULE5
        if (sclk_fall) begin
          shift_next = shifted; // RULE2
          count_next = count_reg + 4'h1;
          if (last_edge) begin
            sw_next = decode(shifted, sw_reg); // RULE3
            word_next = shifted;
            upd_next = 1'b1;
            state_next = smx_pkg::SMX_IDLE;
          end
        end
      end
      default: state_next = smx_pkg::SMX_IDLE;
    endcase
  end

  // Core clock must exceed twice the serial clock rate RULE7
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= smx_pkg::SMX_IDLE;
      shift_reg <= smx_pkg::WORD_RESET;
      count_reg <= 4'h0;
      sw_reg <= smx_pkg::SWITCH_RESET;
      word_reg <= smx_pkg::WORD_RESET;
      upd_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      count_reg <= count_next;
      sw_reg <= sw_next;
      word_reg <= word_next;
      upd_reg <= upd_next;
    end
  end

  assign switch_on = sw_reg;
  assign last_word = word_reg;
  assign update_pulse = upd_reg;
  assign frame_busy = state_reg == smx_pkg::SMX_SHIFT;
endmodule
`default_nettype wire

/* smx_serial_mux_switch_control_bench.sv */
// Self-checking bench for the serial mux switch control front end
// Assumes the host model and checker files are compiled first
`timescale 1ns/1ps
`default_nettype none
module smx_serial_mux_switch_control_bench;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  wire frame_sync_n, serial_clk, serial_data;
  smx_pkg::smx_switch_t switch_on;
  logic [7:0] last_word;
  logic update_pulse, frame_busy;
  int miscompares = 0, check_count = 0;
  logic [7:0] words [4] = '{8'h03, 8'h80, 8'h4F, 8'h6A};
  logic [31:0] exp_sw [4] = '{32'h0008_0008, 32'h0, 32'h8000, 32'h8000};
  initial forever #50 core_clk = ~core_clk;
  smx_host host (.*);
  smx_serial_mux_switch_control dut (.*);
  task automatic check(input logic [40:0] seen, input logic [40:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    check({switch_on, last_word, frame_busy}, 41'h0);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    for (int i = 0; i < 4; i++) begin
      host.send(words[i], i[0]);
      repeat (2) @(posedge core_clk);
      check({switch_on, last_word, frame_busy}, {exp_sw[i], words[i], 1'b0});
    end
    rst_n <= 1'b0;
    @(posedge core_clk);
    check({switch_on, last_word, frame_busy}, 41'h0);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    host.send(8'h05, 1'b0);
    repeat (2) @(posedge core_clk);
    check({switch_on, last_word, frame_busy}, {32'h0020_0020, 8'h05, 1'b0});
    give_verdict();
  end
  initial begin
    #200000;
    miscompares++;
    give_verdict();
  end
endmodule
bind smx_serial_mux_switch_control smx_sva chk (.*);
`default_nettype wire

/* smx_sva.sv */
// Port assertions for the serial mux switch control front end
// Assumes binding to the top design module
`timescale 1ns/1ps
`default_nettype none
module smx_sva (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic frame_sync_n,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire smx_pkg::smx_switch_t switch_on,
  input wire logic [7:0] last_word,
  input wire logic update_pulse,
  input wire logic frame_busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence word_done;
    update_pulse && !(last_word[6] && last_word[5]);
  endsequence
  chk_sync_arms: assert property ($fell(frame_sync_n) && !frame_busy
    |-> ##[1:5] frame_busy) else $error("sync did not arm");
  chk_one_pulse: assert property (update_pulse |=> !update_pulse)
    else $error("update pulse too long");
  chk_done_idle: assert property (update_pulse |-> !frame_busy)
    else $error("busy after word");
  chk_all_off: assert property (word_done and last_word[7]
    |-> switch_on == '0) else $error("all-off ignored");
  chk_keep_both: assert property (update_pulse && last_word[6]
    && last_word[5] |-> $stable(switch_on)) else $error("switches moved");
  chk_addr_a: assert property (word_done and last_word[7:5] == 3'h0
    |-> switch_on.bank_a == (16'h1 << last_word[3:0])) else $error("bad addr");
  chk_hold_quiet: assert property (!update_pulse |-> $stable(switch_on)
    && $stable(last_word)) else $error("change without update");
  chk_one_hot: assert property ($onehot0(switch_on.bank_a)
    && $onehot0(switch_on.bank_b)) else $error("several switches closed");
endmodule
`default_nettype wire
